// ==== src/cfg_router_params.svh ====
// Behaviour
// - 32-bit pointer lives at I/O 0CF8h-0CFBh, resets to zero, read/write.
// - only full DWord accesses touch the pointer; byte/word pass to hub link.
// - pointer bit 31 enables configuration access through the data window.
// - pointer bits 30:24 read zero; bits 1:0 are read-only, unchanged by writes.
// - bus zero with a non-internal device number forwards onto the hub link.
// - bus zero claims devices 0, 1, 2, 3 and 6 internally.
// - bus equal to the secondary bus number gives graphics-bus Type 0 cycle.
// - bus above secondary, up to subordinate, gives graphics-bus Type 1 cycle.
// - non-zero bus outside secondary..subordinate gives hub-link Type 1 cycle.
// - graphics Type 0 drives one IDSEL line, line 16 plus device number.
// - device above 15 runs Type 0 without IDSEL; master abort is reported.
// - device number goes to address bits 15:11, except graphics Type 0 where bits 15:11 are zero.
// - function number goes to address bits 10:8 on both interfaces.
// - internal device accesses with non-zero function number are ignored.
// - register number goes to address bits 7:2 on both interfaces.
// - data window 0CFCh-0CFFh turns accesses into config cycles when enabled.
// - hub-link Type 1 address is pointer bits 31:2 with bits 1:0 set to 01.
`ifndef CFG_ROUTER_PARAMS_SVH
`define CFG_ROUTER_PARAMS_SVH

// ----------------------------------------------------------------------
// register map and layout
// ----------------------------------------------------------------------
`define CFG_PTR_IO_ADDR 16'h0CF8
`define CFG_WINDOW_IO_ADDR 16'h0CFC
`define CFG_PTR_RESET 32'h00000000
`define CFG_PTR_WR_MASK 32'h80FFFFFC
`define CFG_ENABLE_BIT 31
`define CFG_FULL_BE 4'hF
`define CFG_NO_TARGET_DATA 32'hFFFFFFFF
`define CFG_INTERNAL_DEV_MASK 32'h0000004F
`define CFG_HUB_TYPE0_CODE 2'h0
`define CFG_TYPE1_CODE 2'h1
`define CFG_IDSEL_ONE 16'h0001

`endif

// ==== src/cfg_router_pkg.sv ====
package cfg_router_pkg;

  // ----------------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_DONE = 2'h3
  } phase_e;

  typedef enum logic [2:0] {
    RT_IGNORE = 3'h0,
    RT_INTERNAL = 3'h1,
    RT_HUB_T0 = 3'h2,
    RT_HUB_T1 = 3'h3,
    RT_GPB_T0 = 3'h4,
    RT_GPB_T1 = 3'h5
  } route_e;

  typedef enum logic [1:0] {
    TGT_NONE = 2'h0,
    TGT_HUB = 2'h1,
    TGT_GPB = 2'h2,
    TGT_INT = 2'h3
  } target_e;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic cfg;
    logic write;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } hub_link_req_s;

  typedef struct packed {
    logic type1;
    logic write;
    logic [31:0] graphics_port_ad_lines;
    logic [3:0] be;
    logic [31:0] wdata;
  } graphics_port_bus_req_s;

  typedef struct packed {
    logic write;
    logic [4:0] dev;
    logic [5:0] reg_num;
    logic [3:0] be;
    logic [31:0] wdata;
  } internal_req_s;

  typedef struct packed {
    route_e route;
    logic [31:0] hub_addr;
    logic [31:0] gpb_ad;
    logic no_idsel;
  } route_s;

  typedef struct packed {
    logic [31:0] value;
  } ptr_st_s;

  typedef struct packed {
    phase_e phase;
    target_e target;
    logic no_idsel;
    logic abort;
    hub_link_req_s hub;
    graphics_port_bus_req_s gpb;
    internal_req_s internal;
    logic [31:0] rdata;
  } router_st_s;

endpackage

// ==== src/cfg_pointer_reg.sv ====
`timescale 1ns/1ps
`include "cfg_router_params.svh"

module cfg_pointer_reg
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [31:0] cfg_cycle_pointer
);

  cfg_router_pkg::ptr_st_s st;
  cfg_router_pkg::ptr_st_s next_st;

  // ----------------------------------------------------------------------
  // pointer storage
  // ----------------------------------------------------------------------
  // only writable bits take the new value, the rest hold zero
  always_comb
  begin
    next_st = st;
    if (wr_en)
    begin
      next_st.value = wdata & `CFG_PTR_WR_MASK;
    end
  end

  // clear to zero on reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st <= '{value: `CFG_PTR_RESET};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cfg_cycle_pointer = st.value;

endmodule

// ==== src/cfg_route_decode.sv ====
`timescale 1ns/1ps
`include "cfg_router_params.svh"

module cfg_route_decode
(
  input wire logic [31:0] cfg_cycle_pointer,
  input wire logic [7:0] secondary_bus,
  input wire logic [7:0] subordinate_bus,
  output cfg_router_pkg::route_s route
);

  logic [7:0] bus_num;
  logic [4:0] dev_num;
  logic [2:0] func_num;
  logic [15:0] idsel;
  logic [31:0] internal_mask;

  assign bus_num = cfg_cycle_pointer[23:16];
  assign dev_num = cfg_cycle_pointer[15:11];
  assign func_num = cfg_cycle_pointer[10:8];
  assign internal_mask = `CFG_INTERNAL_DEV_MASK;

  // ----------------------------------------------------------------------
  // target selection and address formatting
  // ----------------------------------------------------------------------
  // one-hot idsel for devices 0..15, none above
  always_comb
  begin
    idsel = '0;
    if (!dev_num[4])
    begin
      idsel = `CFG_IDSEL_ONE << dev_num[3:0];
    end
  end

  // pick the destination from bus and device numbers
  always_comb
  begin
    route.route = cfg_router_pkg::RT_HUB_T1;
    if (bus_num == 8'h00)
    begin
      if (internal_mask[dev_num])
      begin
        if (func_num != 3'h0)
        begin
          route.route = cfg_router_pkg::RT_IGNORE;
        end
        else
        begin
          route.route = cfg_router_pkg::RT_INTERNAL;
        end
      end
      else
      begin
        route.route = cfg_router_pkg::RT_HUB_T0;
      end
    end
    else if (bus_num == secondary_bus)
    begin
      route.route = cfg_router_pkg::RT_GPB_T0;
    end
    else if (bus_num > secondary_bus && bus_num <= subordinate_bus)
    begin
      route.route = cfg_router_pkg::RT_GPB_T1;
    end
    // hub link: device, function and register fields kept in place
    if (route.route == cfg_router_pkg::RT_HUB_T1)
    begin
      route.hub_addr = {cfg_cycle_pointer[31:2], `CFG_TYPE1_CODE};
    end
    else
    begin
      route.hub_addr = {8'h00, cfg_cycle_pointer[23:2],
                        `CFG_HUB_TYPE0_CODE};
    end
    // graphics bus: type 0 carries idsel on the upper lines
    if (route.route == cfg_router_pkg::RT_GPB_T0)
    begin
      route.gpb_ad = {idsel, 5'h00, cfg_cycle_pointer[10:2],
                      `CFG_HUB_TYPE0_CODE};
    end
    else
    begin
      route.gpb_ad = {8'h00, cfg_cycle_pointer[23:2],
                      `CFG_TYPE1_CODE};
    end
    route.no_idsel = dev_num[4];
  end

endmodule

// ==== src/config_cycle_address_router.sv ====
`timescale 1ns/1ps
`include "cfg_router_params.svh"

module config_cycle_address_router
(
  input wire logic clk_sys,
  input wire logic rst,
  // processor i/o request
  input wire logic io_valid,
  input cfg_router_pkg::io_req_s io_req,
  output logic io_ready,
  output logic io_ack,
  output logic [31:0] io_rdata,
  // bus numbers held by the virtual bridge
  input wire logic [7:0] secondary_bus,
  input wire logic [7:0] subordinate_bus,
  // hub link
  output logic hub_link_valid,
  output cfg_router_pkg::hub_link_req_s hub_link_req,
  input wire logic hub_link_done,
  input wire logic [31:0] hub_link_rdata,
  // graphics port bus
  output logic graphics_port_bus_valid,
  output cfg_router_pkg::graphics_port_bus_req_s graphics_port_bus_req,
  input wire logic graphics_port_bus_done,
  input wire logic [31:0] graphics_port_bus_rdata,
  output logic cfg_master_abort,
  // internal configuration devices
  output logic internal_valid,
  output cfg_router_pkg::internal_req_s internal_req,
  input wire logic internal_done,
  input wire logic [31:0] internal_rdata,
  // pointer contents for the rest of the device
  output logic [31:0] cfg_cycle_pointer,
  output logic cfg_access_enable
);

  cfg_router_pkg::router_st_s st;
  cfg_router_pkg::router_st_s next_st;
  cfg_router_pkg::route_s route;
  logic is_ptr;
  logic is_window;
  logic full_dword;
  logic take;
  logic ptr_wr;

  // ----------------------------------------------------------------------
  // pointer register and route decoder
  // ----------------------------------------------------------------------
  cfg_pointer_reg i_cfg_pointer_reg
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(ptr_wr),
    .wdata(io_req.wdata),
    .cfg_cycle_pointer(cfg_cycle_pointer)
  );

  cfg_route_decode i_cfg_route_decode
  (
    .cfg_cycle_pointer(cfg_cycle_pointer),
    .secondary_bus(secondary_bus),
    .subordinate_bus(subordinate_bus),
    .route(route)
  );

  // ----------------------------------------------------------------------
  // request classification
  // ----------------------------------------------------------------------
  // address decode of the two i/o locations
  assign cfg_access_enable = cfg_cycle_pointer[`CFG_ENABLE_BIT];
  assign is_ptr = io_req.addr == `CFG_PTR_IO_ADDR;
  assign is_window = io_req.addr == `CFG_WINDOW_IO_ADDR;
  assign full_dword = io_req.be == `CFG_FULL_BE;
  assign io_ready = st.phase == cfg_router_pkg::ST_IDLE;
  assign take = io_valid && io_ready;
  // pointer latches only on a full dword write
  assign ptr_wr = take && is_ptr && full_dword && io_req.write;

  // ----------------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------------
  // one access at a time: accept, wait for the target, answer
  always_comb
  begin
    next_st = st;
    unique case (st.phase)
      cfg_router_pkg::ST_IDLE:
      begin
        next_st.abort = 1'b0;
        if (take)
        begin
          next_st.phase = cfg_router_pkg::ST_DONE;
          next_st.target = cfg_router_pkg::TGT_NONE;
          next_st.rdata = `CFG_NO_TARGET_DATA;
          next_st.no_idsel = 1'b0;
          if (is_ptr && full_dword)
          begin
            // pointer access completes locally
            next_st.rdata = io_req.write ? 32'h00000000
                                         : cfg_cycle_pointer;
          end
          else if (is_ptr)
          begin
            // partial access passes through as plain i/o
            next_st.phase = cfg_router_pkg::ST_WAIT;
            next_st.target = cfg_router_pkg::TGT_HUB;
            next_st.hub.cfg = 1'b0;
            next_st.hub.write = io_req.write;
            next_st.hub.addr = {16'h0000, io_req.addr};
            next_st.hub.be = io_req.be;
            next_st.hub.wdata = io_req.wdata;
          end
          else if (is_window && cfg_access_enable)
          begin
            unique case (route.route)
              cfg_router_pkg::RT_INTERNAL:
              begin
                next_st.phase = cfg_router_pkg::ST_WAIT;
                next_st.target = cfg_router_pkg::TGT_INT;
                next_st.internal.write = io_req.write;
                next_st.internal.dev = cfg_cycle_pointer[15:11];
                next_st.internal.reg_num = cfg_cycle_pointer[7:2];
                next_st.internal.be = io_req.be;
                next_st.internal.wdata = io_req.wdata;
              end
              cfg_router_pkg::RT_HUB_T0, cfg_router_pkg::RT_HUB_T1:
              begin
                next_st.phase = cfg_router_pkg::ST_WAIT;
                next_st.target = cfg_router_pkg::TGT_HUB;
                next_st.hub.cfg = 1'b1;
                next_st.hub.write = io_req.write;
                next_st.hub.addr = route.hub_addr;
                next_st.hub.be = io_req.be;
                next_st.hub.wdata = io_req.wdata;
              end
              cfg_router_pkg::RT_GPB_T0, cfg_router_pkg::RT_GPB_T1:
              begin
                next_st.phase = cfg_router_pkg::ST_WAIT;
                next_st.target = cfg_router_pkg::TGT_GPB;
                next_st.gpb.type1 = route.route == cfg_router_pkg::RT_GPB_T1;
                next_st.gpb.write = io_req.write;
                next_st.gpb.graphics_port_ad_lines = route.gpb_ad;
                next_st.gpb.be = io_req.be;
                next_st.gpb.wdata = io_req.wdata;
                next_st.no_idsel = route.no_idsel &&
                  route.route == cfg_router_pkg::RT_GPB_T0;
              end
              default:
              begin
                // ignored internal function: answer with no-target data
                next_st.target = cfg_router_pkg::TGT_NONE;
              end
            endcase
          end
          else
          begin
            // disabled window or foreign address: no cycle anywhere
            next_st.target = cfg_router_pkg::TGT_NONE;
          end
        end
      end
      cfg_router_pkg::ST_WAIT:
      begin
        // capture the answer of whichever target was started
        unique case (st.target)
          cfg_router_pkg::TGT_HUB:
          begin
            if (hub_link_done)
            begin
              next_st.phase = cfg_router_pkg::ST_DONE;
              next_st.rdata = hub_link_rdata;
            end
          end
          cfg_router_pkg::TGT_GPB:
          begin
            if (graphics_port_bus_done)
            begin
              next_st.phase = cfg_router_pkg::ST_DONE;
              next_st.rdata = graphics_port_bus_rdata;
              next_st.abort = st.no_idsel;
            end
          end
          cfg_router_pkg::TGT_INT:
          begin
            if (internal_done)
            begin
              next_st.phase = cfg_router_pkg::ST_DONE;
              next_st.rdata = internal_rdata;
            end
          end
          default:
          begin
            next_st.phase = cfg_router_pkg::ST_DONE;
          end
        endcase
      end
      cfg_router_pkg::ST_DONE:
      begin
        next_st.phase = cfg_router_pkg::ST_IDLE;
        next_st.target = cfg_router_pkg::TGT_NONE;
      end
      default:
      begin
        next_st.phase = cfg_router_pkg::ST_IDLE;
      end
    endcase
  end

  // state register with defined reset values
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // request strobes stand while waiting on the chosen target
  assign hub_link_valid = st.phase == cfg_router_pkg::ST_WAIT &&
                          st.target == cfg_router_pkg::TGT_HUB;
  assign graphics_port_bus_valid = st.phase == cfg_router_pkg::ST_WAIT &&
                                   st.target == cfg_router_pkg::TGT_GPB;
  assign internal_valid = st.phase == cfg_router_pkg::ST_WAIT &&
                          st.target == cfg_router_pkg::TGT_INT;
  assign hub_link_req = st.hub;
  assign graphics_port_bus_req = st.gpb;
  assign internal_req = st.internal;

  // answer to the processor, one cycle
  assign io_ack = st.phase == cfg_router_pkg::ST_DONE;
  assign io_rdata = st.rdata;
  assign cfg_master_abort = io_ack && st.abort;

endmodule

// ==== dv/config_cycle_address_router_monitor.sv ====
`timescale 1ns/1ps

module config_cycle_address_router_monitor
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic io_valid,
  input cfg_router_pkg::io_req_s io_req,
  input wire logic io_ready,
  input wire logic io_ack,
  input wire logic [31:0] io_rdata,
  input wire logic hub_link_valid,
  input cfg_router_pkg::hub_link_req_s hub_link_req,
  input wire logic graphics_port_bus_valid,
  input cfg_router_pkg::graphics_port_bus_req_s graphics_port_bus_req,
  input wire logic internal_valid,
  input wire logic [31:0] cfg_cycle_pointer,
  input wire logic cfg_access_enable,
  input wire logic cfg_master_abort
);
  // ----------------------------------------
  // decoded request and expected select
  // ----------------------------------------
  logic take;
  logic [31:0] ptr;
  logic [15:0] idsel;
  assign take = io_valid && io_ready;
  assign ptr = cfg_cycle_pointer;
  assign idsel = ptr[15] ? 16'h0000 : 16'h0001 << ptr[14:11];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_ptr_write;
    take && io_req.write && io_req.addr == 16'h0CF8 && io_req.be == 4'hF
      |=> ptr == ($past(io_req.wdata) & 32'h80FFFFFC);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("ptr write");
  property p_byte_pass;
    take && io_req.addr == 16'h0CF8 && io_req.be != 4'hF |=> hub_link_valid
      && !hub_link_req.cfg && hub_link_req.addr == 32'h00000CF8;
  endproperty
  a_byte_pass: assert property (p_byte_pass) else $error("byte pass");
  property p_disabled;
    take && io_req.addr == 16'h0CFC && !cfg_access_enable |=> io_ack
      && io_rdata == 32'hFFFFFFFF && !hub_link_valid
      && !graphics_port_bus_valid && !internal_valid;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled");
  property p_hub_t1;
    hub_link_valid && hub_link_req.cfg && ptr[23:16] != 8'h00
      |-> hub_link_req.addr == {ptr[31:2], 2'h1};
  endproperty
  a_hub_t1: assert property (p_hub_t1) else $error("hub type1");
  property p_hub_bus0;
    hub_link_valid && hub_link_req.cfg && ptr[23:16] == 8'h00
      |-> hub_link_req.addr == {8'h00, ptr[23:2], 2'h0};
  endproperty
  a_hub_bus0: assert property (p_hub_bus0) else $error("hub bus0");
  property p_gpb_t0;
    graphics_port_bus_valid && !graphics_port_bus_req.type1
      |-> graphics_port_bus_req.graphics_port_ad_lines
      == {idsel, 5'h00, ptr[10:2], 2'h0} && ptr[23:16] == $past(ptr[23:16]);
  endproperty
  a_gpb_t0: assert property (p_gpb_t0) else $error("gpb type0");
  property p_gpb_t1;
    graphics_port_bus_valid && graphics_port_bus_req.type1
      |-> graphics_port_bus_req.graphics_port_ad_lines
      == {8'h00, ptr[23:2], 2'h1};
  endproperty
  a_gpb_t1: assert property (p_gpb_t1) else $error("gpb type1");
  property p_internal;
    $rose(internal_valid) |-> ptr[23:16] == 8'h00 && ptr[10:8] == 3'h0
      && ptr[15:11] inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h06};
  endproperty
  a_internal: assert property (p_internal) else $error("internal");
  property p_abort;
    cfg_master_abort |-> io_ack && ptr[15] && ptr[23:16] != 8'h00;
  endproperty
  a_abort: assert property (p_abort) else $error("abort");
endmodule

bind config_cycle_address_router config_cycle_address_router_monitor i_mon
(
  .clk_sys, .rst, .io_valid, .io_req, .io_ready, .io_ack, .io_rdata,
  .hub_link_valid, .hub_link_req, .graphics_port_bus_valid,
  .graphics_port_bus_req, .internal_valid, .cfg_cycle_pointer,
  .cfg_access_enable, .cfg_master_abort
);

// ==== dv/cfg_far_side_model.sv ====
`timescale 1ns/1ps

module cfg_far_side_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] delay,
  input wire logic hub_link_valid,
  input cfg_router_pkg::hub_link_req_s hub_link_req,
  output logic hub_link_done,
  output logic [31:0] hub_link_rdata,
  input wire logic graphics_port_bus_valid,
  input cfg_router_pkg::graphics_port_bus_req_s graphics_port_bus_req,
  output logic graphics_port_bus_done,
  output logic [31:0] graphics_port_bus_rdata,
  input wire logic internal_valid,
  input cfg_router_pkg::internal_req_s internal_req,
  output logic internal_done,
  output logic [31:0] internal_rdata
);
  logic [3:0] wait_cnt;
  logic [31:0] noise;
  logic busy;
  logic fire;
  assign busy = hub_link_valid | graphics_port_bus_valid | internal_valid;
  assign fire = !rst && busy && wait_cnt == delay
    && !(hub_link_done | graphics_port_bus_done | internal_done);

  // one shared wait counter; data lines churn outside the answer cycle
  always_ff @(posedge clk_sys)
  begin
    noise <= rst ? 32'h00000000 : noise + 32'h9E3779B9;
    wait_cnt <= (busy && !fire && !rst) ? wait_cnt + 4'h1 : 4'h0;
    hub_link_done <= fire && hub_link_valid;
    graphics_port_bus_done <= fire && graphics_port_bus_valid;
    internal_done <= fire && internal_valid;
    // a write answers with its data folded with its byte enables
    hub_link_rdata <= !(fire && hub_link_valid) ? noise
      : hub_link_req.write
      ? hub_link_req.wdata ^ {28'h0000000, hub_link_req.be}
      : hub_link_req.addr ^ (hub_link_req.cfg ? 32'h11110000 : 32'h44440000);
    graphics_port_bus_rdata <= !(fire && graphics_port_bus_valid) ? ~noise
      : graphics_port_bus_req.write
      ? graphics_port_bus_req.wdata ^ {28'h0000000, graphics_port_bus_req.be}
      : graphics_port_bus_req.graphics_port_ad_lines ^ 32'h22220000;
    internal_rdata <= !(fire && internal_valid) ? noise ^ 32'h0F0F0F0F
      : internal_req.write
      ? internal_req.wdata ^ {28'h0000000, internal_req.be}
      : {21'h000000, internal_req.dev, internal_req.reg_num};
  end
endmodule

// ==== dv/config_cycle_address_router_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) check(nm, ex, got)

module config_cycle_address_router_tb;
  logic clk_sys, rst, io_valid, io_ready, io_ack, cfg_master_abort;
  logic hub_link_valid, hub_link_done, internal_valid, internal_done;
  logic graphics_port_bus_valid, graphics_port_bus_done, cfg_access_enable;
  logic [31:0] io_rdata, hub_link_rdata, graphics_port_bus_rdata;
  logic [31:0] internal_rdata, cfg_cycle_pointer, last_rd;
  logic [7:0] secondary_bus, subordinate_bus;
  logic [3:0] delay;
  logic last_abort;
  cfg_router_pkg::io_req_s io_req;
  cfg_router_pkg::hub_link_req_s hub_link_req;
  cfg_router_pkg::graphics_port_bus_req_s graphics_port_bus_req;
  cfg_router_pkg::internal_req_s internal_req;
  int bad_count, total_checks;

  config_cycle_address_router i_config_cycle_address_router (.clk_sys, .rst,
    .io_valid, .io_req, .io_ready, .io_ack, .io_rdata, .secondary_bus,
    .subordinate_bus, .hub_link_valid, .hub_link_req, .hub_link_done,
    .hub_link_rdata, .graphics_port_bus_valid, .graphics_port_bus_req,
    .graphics_port_bus_done, .graphics_port_bus_rdata, .cfg_master_abort,
    .internal_valid, .internal_req, .internal_done, .internal_rdata,
    .cfg_cycle_pointer, .cfg_access_enable);
  cfg_far_side_model i_cfg_far_side_model (.clk_sys, .rst, .delay,
    .hub_link_valid, .hub_link_req, .hub_link_done, .hub_link_rdata,
    .graphics_port_bus_valid, .graphics_port_bus_req, .graphics_port_bus_done,
    .graphics_port_bus_rdata, .internal_valid, .internal_req, .internal_done,
    .internal_rdata);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] ex, got);
    total_checks++;
    if (got !== ex)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded wait for ready (ack=0) or ack (ack=1), sampled between edges
  task automatic wait_sig(input bit ack);
    int n;
    n = 0;
    while ((ack ? io_ack : io_ready) !== 1'b1)
    begin
      n++;
      if (n > 60)
      begin
        bad_count++;
        $display("BAD wait exp 1 got timeout");
        final_report();
      end
      @(posedge clk_sys);
      #1;
    end
  endtask

  // request held until the edge that takes it, answer taken with ack
  task automatic io(input logic wr, input logic [15:0] adr,
    input logic [3:0] be, input logic [31:0] wd);
    io_valid = 1'b1;
    io_req = '{wr, adr, be, wd};
    wait_sig(1'b0);
    @(posedge clk_sys);
    #1;
    io_valid = 1'b0;
    wait_sig(1'b1);
    last_rd = io_rdata;
    last_abort = cfg_master_abort;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic cfg_rd(input logic [7:0] bus, input logic [4:0] dev,
    input logic [2:0] fn, input logic [5:0] rg);
    io(1'b1, 16'h0CF8, 4'hF, {8'h80, bus, dev, fn, rg, 2'h0});
    io(1'b0, 16'h0CFC, 4'hF, 32'h00000000);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_pointer();
    io(1'b0, 16'h0CF8, 4'hF, 32'h00000000);
    `CHK("ptr reset", 32'h00000000, last_rd);
    io(1'b1, 16'h0CF8, 4'hF, 32'hFFFFFFFF);
    `CHK("ptr wr ack", 32'h00000000, last_rd);
    io(1'b0, 16'h0CF8, 4'hF, 32'h00000000);
    `CHK("ptr mask", 32'h80FFFFFC, last_rd);
    `CHK("enable", 32'h1, {31'h0, cfg_access_enable});
    io(1'b0, 16'h0CF8, 4'h3, 32'h00000000);
    `CHK("word pass", 32'h44440CF8, last_rd);
    io(1'b1, 16'h0CF8, 4'h1, 32'h000000A5);
    `CHK("byte write", 32'h000000A4, last_rd);
    `CHK("ptr kept", 32'h80FFFFFC, cfg_cycle_pointer);
  endtask

  task automatic t_disabled();
    io(1'b1, 16'h0CF8, 4'hF, 32'h00003800);
    `CHK("disable", 32'h0, {31'h0, cfg_access_enable});
    io(1'b0, 16'h0CFC, 4'hF, 32'h00000000);
    `CHK("off read", 32'hFFFFFFFF, last_rd);
    io(1'b1, 16'h0CFC, 4'hF, 32'h12345678);
    `CHK("off write", 32'h00003800, cfg_cycle_pointer);
    io(1'b0, 16'h0CF0, 4'hF, 32'h00000000);
    `CHK("foreign", 32'hFFFFFFFF, last_rd);
  endtask

  task automatic t_bus0();
    logic [4:0] d;
    for (int i = 0; i < 8; i++)
    begin
      d = i[4:0];
      cfg_rd(8'h00, d, 3'h0, 6'h05);
      if (d inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h06})
        `CHK("internal", {21'h0, d, 6'h05}, last_rd);
      else
        `CHK("bus0 hub", {16'h1111, d, 11'h014}, last_rd);
    end
    cfg_rd(8'h00, 5'h01, 3'h3, 6'h05);
    `CHK("fn ignored", 32'hFFFFFFFF, last_rd);
    cfg_rd(8'h00, 5'h09, 3'h5, 6'h21);
    `CHK("fn to hub", {16'h1111, 5'h09, 11'h584}, last_rd);
    io(1'b1, 16'h0CFC, 4'h3, 32'h0BADF00D);
    `CHK("hub write", 32'h0BADF00E, last_rd);
    cfg_rd(8'h00, 5'h02, 3'h0, 6'h05);
    io(1'b1, 16'h0CFC, 4'h6, 32'h5A5AA5A5);
    `CHK("int write", 32'h5A5AA5A3, last_rd);
  endtask

  task automatic t_graphics();
    logic [4:0] devs [5];
    logic [7:0] buses [5];
    logic [15:0] sel;
    devs = '{5'h00, 5'h05, 5'h0F, 5'h10, 5'h1F};
    buses = '{8'h06, 8'h09, 8'h04, 8'h0A, 8'hFF};
    delay = 4'h3;
    foreach (devs[i])
    begin
      cfg_rd(8'h05, devs[i], 3'h2, 6'h3F);
      sel = devs[i][4] ? 16'h0000 : (16'h0001 << devs[i][3:0]);
      `CHK("type0", {sel ^ 16'h2222, 16'h02FC}, last_rd);
      `CHK("abort", {31'h0, devs[i][4]}, {31'h0, last_abort});
    end
    io(1'b1, 16'h0CFC, 4'hC, 32'hC3C3C3C3);
    `CHK("gpb write", 32'hC3C3C3CF, last_rd);
    `CHK("abort wr", 32'h1, {31'h0, last_abort});
    foreach (buses[i])
    begin
      cfg_rd(buses[i], 5'h03, 3'h1, 6'h02);
      if (i < 2)
        `CHK("gpb t1", {8'h22, buses[i] ^ 8'h22, 16'h1909}, last_rd);
      else
        `CHK("hub t1", {8'h91, buses[i] ^ 8'h11, 16'h1909}, last_rd);
    end
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial
  begin
    rst = 1'b1;
    io_valid = 1'b0;
    io_req = '0;
    secondary_bus = 8'h05;
    subordinate_bus = 8'h09;
    delay = 4'h0;
    bad_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_pointer();
    t_disabled();
    t_bus0();
    t_graphics();
    final_report();
  end
endmodule
